/* design/sxd_dispatch.sv */
// System exception detection, priority and dispatch with Avalon-MM registers
//
// The Avalon-MM slave port and the placing of the registers were chosen for this implementation.
module sxd_dispatch import sxd_pkg::*; #(
    parameter bit DEFER_CR = 1'b1
) (
    input wire logic CLOCK_I,
    input wire logic RESET_I,
    input wire logic [3:0] AVS_ADDRESS_I,
    input wire logic AVS_READ_I,
    input wire logic AVS_WRITE_I,
    input wire logic [31:0] AVS_WRITEDATA_I,
    input wire logic [3:0] AVS_BYTEENABLE_I,
    output logic [31:0] AVS_READDATA_O,
    output logic AVS_WAITREQUEST_O,
    input wire sxd_evt_t OLD_EVT_I,
    input wire sxd_evt_t YOUNG_EVT_I,
    input wire sxd_dl_t DEADLOCK_I,
    input wire logic FRAME_DONE_I,
    output sxd_disp_t DISPATCH_O,
    output logic CAT_PENDING_O
);
    function automatic logic [31:0] code(input logic [7:0] cls, input logic [7:0] q);
        code = {16'h0000, cls, q};
    endfunction

    function automatic sxd_disp_t classify(input sxd_evt_t ev, input logic vv,
                                           input logic mp, input logic io,
                                           input logic crbad);
        sxd_disp_t d;
        logic vtouch;
        d = '0;
        vtouch = ev.vreg_rd | ev.vreg_wr | ev.vlen_acc | ev.vstride_acc
            | ev.vmask_acc | ev.vflag_acc | ev.elem_store;
        d.valid = ev.valid;
        d.vec = VEC_SYS;
        if (ev.undef_op) begin
            d.cause = code(CLS_UNDEF, Q_NONE);
        end else if (ev.priv_op && ev.ring != 3'h0) begin
            d.cause = code(CLS_RING, QR_PRIV);
        end else if (vtouch && !vv) begin
            d.vec = VEC_VV;
            d.cause = code(CLS_VV, Q_NONE);
        end else if (ev.inward_addr) begin
            d.cause = code(CLS_RING, QR_INWARD);
        end else if (ev.sysc_outward) begin
            d.cause = code(CLS_RING, QR_OUT_SYSC);
        end else if (ev.ret_inward && ev.ret_ext) begin
            d.cause = code(CLS_RING, QR_IN_RET);
        end else if (ev.bad_gate) begin
            d.cause = code(CLS_RING, QR_GATE);
        end else if (ev.bad_frame_len) begin
            d.cause = code(CLS_RING, QR_FRAME);
        end else if (mp && crbad && !DEFER_CR) begin
            d.cause = code(CLS_RING, QR_COMM);
            d.ctx_frame = 1'b1;
            d.clr_psw = 1'b1;
        end else if (mp && ev.trap_bad) begin
            d.cause = code(CLS_RING, QR_TRAP);
        end else if (ev.rd_deny) begin
            d.cause = code(CLS_PTE, QP_READ);
            d.ctx_frame = 1'b1;
            d.page_fault = 1'b1;
        end else if (ev.wr_deny) begin
            d.cause = code(CLS_PTE, QP_WRITE);
            d.ctx_frame = 1'b1;
            d.page_fault = 1'b1;
        end else if (ev.ex_deny) begin
            d.cause = code(CLS_PTE, QP_EXEC);
            d.ctx_frame = 1'b1;
            d.page_fault = 1'b1;
        end else if (ev.sdr_inv) begin
            d.cause = code(CLS_PTE, QP_SDR);
            d.ctx_frame = 1'b1;
            d.page_fault = 1'b1;
        end else if (ev.l1_inv) begin
            d.cause = code(CLS_PTE, QP_L1);
            d.ctx_frame = 1'b1;
            d.page_fault = 1'b1;
        end else if (ev.l2_inv) begin
            d.cause = code(CLS_PTE, QP_L2);
            d.ctx_frame = 1'b1;
            d.page_fault = 1'b1;
        end else if (mp && ev.lt_inv) begin
            d.cause = code(CLS_PTE, QP_LT);
            d.ctx_frame = 1'b1;
            d.page_fault = 1'b1;
        end else if (io && ev.io_inv) begin
            d.cause = code(CLS_PTE, QP_IO);
            d.ctx_frame = 1'b1;
        end else if (ev.nonres_data || ev.nonres_tbl) begin
            // Reached only when every enabled validity and access check above passed
            d.cause = code(CLS_NONRES, ev.nonres_data ? QN_DATA : QN_TABLE);
            d.ctx_frame = 1'b1;
            d.page_fault = 1'b1;
        end else begin
            d.valid = 1'b0;
        end
        classify = d;
    endfunction

    logic [2:0] ctrl_r;
    logic [31:0] cause_r;
    logic [31:0] vector_r;
    logic cat_r;
    logic cat_nxt;
    logic sysc_open_r;
    logic sysc_open_nxt;
    logic wait_r;
    logic [31:0] rdata_r;
    sxd_state_t st_r;
    sxd_state_t st_nxt;
    sxd_disp_t disp_r;
    sxd_disp_t disp_nxt;

    wire logic bus_req = AVS_READ_I | AVS_WRITE_I;
    wire logic bus_ack = bus_req & ~wait_r;
    wire logic ctrl_we = bus_ack & AVS_WRITE_I & (AVS_ADDRESS_I == REG_CTRL)
        & AVS_BYTEENABLE_I[0];
    wire logic [31:0] status_w = {29'h0, 1'b0, st_r == ST_PFPUSH, cat_r};
    wire logic [31:0] rdata_sel =
        (AVS_ADDRESS_I == REG_CTRL) ? {29'h0, ctrl_r} :
        (AVS_ADDRESS_I == REG_CAUSE) ? cause_r :
        (AVS_ADDRESS_I == REG_STATUS) ? (status_w | {29'h0, sysc_open_r, 2'b00}) :
        (AVS_ADDRESS_I == REG_VECTOR) ? vector_r : 32'h0000_0000;

    wire logic vv = ctrl_r[CTRL_VV];
    wire logic mp = ctrl_r[CTRL_MP];
    wire logic io = ctrl_r[CTRL_IO];
    wire logic crbad0 = OLD_EVT_I.cr_op && ((OLD_EVT_I.cr_addr > CR_LAST)
        || (OLD_EVT_I.cr_addr <= CR_R0_LAST && OLD_EVT_I.ring != 3'h0));
    wire logic crbad1 = YOUNG_EVT_I.cr_op && ((YOUNG_EVT_I.cr_addr > CR_LAST)
        || (YOUNG_EVT_I.cr_addr <= CR_R0_LAST && YOUNG_EVT_I.ring != 3'h0));
    wire sxd_disp_t cls0 = classify(OLD_EVT_I, vv, mp, io, crbad0);
    wire sxd_disp_t cls1 = classify(YOUNG_EVT_I, vv, mp, io, crbad1);
    wire logic cat_take = DEFER_CR && cat_r && !sysc_open_r
        && OLD_EVT_I.valid && OLD_EVT_I.boundary;
    wire logic take0 = !cat_take && cls0.valid;
    wire logic take1 = !cat_take && !cls0.valid && cls1.valid;
    wire logic take_dl = !cat_take && !cls0.valid && !cls1.valid
        && (DEADLOCK_I.last || DEADLOCK_I.hw);
    wire logic cat_set = DEFER_CR && mp && ((OLD_EVT_I.valid && crbad0)
        || (take1 && YOUNG_EVT_I.valid && crbad1));
    wire logic pf_again = (st_r == ST_PFPUSH)
        && ((take0 && cls0.page_fault) || (take1 && cls1.page_fault));

    always_comb begin
        disp_nxt = '0;
        if (cat_take) begin
            disp_nxt.valid = 1'b1;
            disp_nxt.vec = VEC_SYS;
            disp_nxt.cause = code(CLS_RING, QR_COMM);
            disp_nxt.clr_psw = 1'b1;
            disp_nxt.flush_young = 1'b1;
        end else if (pf_again) begin
            disp_nxt.valid = 1'b1;
            disp_nxt.vec = VEC_MACH;
            disp_nxt.cause = code(CLS_HARD, Q_NONE);
            disp_nxt.ctx_frame = 1'b1;
            disp_nxt.flush_young = 1'b1;
        end else if (take0) begin
            disp_nxt = cls0;
            disp_nxt.flush_young = 1'b1;
        end else if (take1) begin
            disp_nxt = cls1;
        end else if (take_dl) begin
            disp_nxt.valid = 1'b1;
            disp_nxt.vec = VEC_DEADLOCK;
            if (DEADLOCK_I.last) begin
                disp_nxt.cause = code(CLS_DL_LAST, Q_NONE);
            end else begin
                disp_nxt.cause = code(CLS_DL_HW, DEADLOCK_I.mixed ? QD_MIXED : QD_SYNC);
            end
        end
    end

    // Set wins over the clear taken at the boundary
    assign cat_nxt = cat_set | (cat_r & ~cat_take);
    assign sysc_open_nxt = (OLD_EVT_I.valid && OLD_EVT_I.sysc_go && (cat_r || cat_set))
        | (sysc_open_r & ~(OLD_EVT_I.valid & OLD_EVT_I.rtn_go));

    always_comb begin
        case (st_r)
            ST_IDLE: st_nxt = (disp_nxt.valid && disp_nxt.page_fault) ? ST_PFPUSH : ST_IDLE;
            ST_PFPUSH: st_nxt = (FRAME_DONE_I || pf_again) ? ST_IDLE : ST_PFPUSH;
            default: st_nxt = ST_IDLE;
        endcase
    end

    // The VV, MP and IO checks are gated by the ctrl_r bits; the deferred trap is held off in a system call entered while it is pending or being set
    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            disp_r <= '0;
            st_r <= ST_IDLE;
            cat_r <= 1'b0;
            sysc_open_r <= 1'b0;
        end else begin
            disp_r <= disp_nxt;
            st_r <= st_nxt;
            cat_r <= cat_nxt;
            sysc_open_r <= sysc_open_nxt;
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            cause_r <= 32'h0000_0000;
            vector_r <= 32'h0000_0000;
        end else if (disp_nxt.valid) begin
            cause_r <= disp_nxt.cause;
            vector_r <= disp_nxt.vec;
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            ctrl_r <= CTRL_RST;
        end else if (ctrl_we) begin
            ctrl_r <= AVS_WRITEDATA_I[2:0];
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            wait_r <= 1'b1;
            rdata_r <= 32'h0000_0000;
        end else begin
            wait_r <= ~(bus_req & wait_r);
            rdata_r <= (bus_req & wait_r) ? rdata_sel : 32'h0000_0000;
        end
    end

    assign AVS_READDATA_O = rdata_r;
    assign AVS_WAITREQUEST_O = wait_r;
    assign DISPATCH_O = disp_r;
    assign CAT_PENDING_O = cat_r;

    default clocking cb @(posedge CLOCK_I);
    endclocking
    default disable iff (RESET_I);

    AST_UNDEF: assert property (take0 && OLD_EVT_I.undef_op && st_r == ST_IDLE
        |=> disp_r.valid && disp_r.vec == VEC_SYS && disp_r.cause == 32'h0000_0100
        && !disp_r.ctx_frame)
        else $error("undefined opcode not dispatched correctly");
    AST_VV_GATE: assert property (disp_r.valid && disp_r.vec == VEC_VV
        |-> $past(!ctrl_r[CTRL_VV]))
        else $error("vector valid trap taken with permit flag set");
    AST_VV_FRAME: assert property (take0 && cls0.vec == VEC_VV
        |=> disp_r.vec == 32'h0000_001C && !disp_r.ctx_frame)
        else $error("vector valid trap frame or vector wrong");
    AST_CAUSE: assert property (disp_r.valid |-> disp_r.cause[31:16] == 16'h0000)
        else $error("cause upper bytes not zero");
    AST_DEADLOCK: assert property (take_dl && DEADLOCK_I.last
        |=> disp_r.vec == 32'h0000_0010 && disp_r.cause == 32'h0000_0000)
        else $error("last thread deadlock dispatch wrong");
    AST_CR_RANGE: assert property (OLD_EVT_I.cr_op && OLD_EVT_I.cr_addr == 16'h8040
        |-> crbad0)
        else $error("unimplemented communication address accepted");
    AST_CAT_SET: assert property (DEFER_CR && mp && OLD_EVT_I.valid && crbad0
        |=> cat_r && CAT_PENDING_O)
        else $error("deferred pending bit not set");
    AST_CAT_TAKE: assert property (cat_take
        |=> disp_r.cause == 32'h0000_0806 && disp_r.clr_psw && (!cat_r || $past(cat_set)))
        else $error("deferred trap not taken correctly");
    AST_SYSC_HOLD: assert property (sysc_open_r && cat_r && !(OLD_EVT_I.valid
        && OLD_EVT_I.rtn_go) |=> !(disp_r.valid && disp_r.cause == 32'h0000_0806))
        else $error("deferred trap taken inside system call");
    AST_HARD: assert property (pf_again
        |=> disp_r.cause[15:8] == CLS_HARD && st_r == ST_IDLE)
        else $error("nested page fault not turned into hard error");
    AST_OLDEST: assert property (!cat_take && !pf_again && cls0.valid && cls1.valid
        |=> disp_r.flush_young && disp_r.cause == $past(cls0.cause))
        else $error("younger exception won over older one");
    AST_BUS: assert property (bus_req && wait_r |=> !AVS_WAITREQUEST_O ##1 AVS_WAITREQUEST_O)
        else $error("bus answer not one cycle wide");
endmodule

/* shared/sxd_pkg.sv */
// Constants and types for the system exception dispatch block
package sxd_pkg;
    localparam logic [31:0] VEC_SYS = 32'h0000_000C;
    localparam logic [31:0] VEC_DEADLOCK = 32'h0000_0010;
    localparam logic [31:0] VEC_VV = 32'h0000_001C;
    localparam logic [31:0] VEC_MACH = 32'h0000_0020;
    localparam logic [7:0] CLS_DL_LAST = 8'h00;
    localparam logic [7:0] CLS_UNDEF = 8'h01;
    localparam logic [7:0] CLS_VV = 8'h02;
    localparam logic [7:0] CLS_DL_HW = 8'h04;
    localparam logic [7:0] CLS_RING = 8'h08;
    localparam logic [7:0] CLS_PTE = 8'h09;
    localparam logic [7:0] CLS_NONRES = 8'h0A;
    localparam logic [7:0] CLS_HARD = 8'h0B;
    localparam logic [7:0] Q_NONE = 8'h00;
    localparam logic [7:0] QR_PRIV = 8'h00;
    localparam logic [7:0] QR_INWARD = 8'h01;
    localparam logic [7:0] QR_OUT_SYSC = 8'h02;
    localparam logic [7:0] QR_IN_RET = 8'h03;
    localparam logic [7:0] QR_GATE = 8'h04;
    localparam logic [7:0] QR_FRAME = 8'h05;
    localparam logic [7:0] QR_COMM = 8'h06;
    localparam logic [7:0] QR_TRAP = 8'h07;
    localparam logic [7:0] QP_READ = 8'h01;
    localparam logic [7:0] QP_WRITE = 8'h02;
    localparam logic [7:0] QP_EXEC = 8'h03;
    localparam logic [7:0] QP_SDR = 8'h04;
    localparam logic [7:0] QP_L1 = 8'h05;
    localparam logic [7:0] QP_L2 = 8'h06;
    localparam logic [7:0] QP_LT = 8'h07;
    localparam logic [7:0] QP_IO = 8'h08;
    localparam logic [7:0] QN_DATA = 8'h00;
    localparam logic [7:0] QN_TABLE = 8'h01;
    localparam logic [7:0] QD_SYNC = 8'h00;
    localparam logic [7:0] QD_MIXED = 8'h01;
    localparam logic [15:0] CR_LAST = 16'h803F;
    localparam logic [15:0] CR_R0_LAST = 16'h00FF;
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_CAUSE = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h8;
    localparam logic [3:0] REG_VECTOR = 4'hC;
    localparam int CTRL_VV = 0;
    localparam int CTRL_MP = 1;
    localparam int CTRL_IO = 2;
    localparam logic [2:0] CTRL_RST = 3'h6;
    localparam int ST_CAT = 0;
    localparam int ST_PUSH = 1;
    localparam int ST_HOLD = 2;

    typedef struct packed {
        logic valid;
        logic [2:0] ring;
        logic undef_op;
        logic vreg_rd;
        logic vreg_wr;
        logic vlen_acc;
        logic vstride_acc;
        logic vmask_acc;
        logic vflag_acc;
        logic elem_store;
        logic priv_op;
        logic inward_addr;
        logic sysc_outward;
        logic ret_inward;
        logic ret_ext;
        logic bad_gate;
        logic bad_frame_len;
        logic cr_op;
        logic [15:0] cr_addr;
        logic trap_bad;
        logic rd_deny;
        logic wr_deny;
        logic ex_deny;
        logic sdr_inv;
        logic l1_inv;
        logic l2_inv;
        logic lt_inv;
        logic io_inv;
        logic nonres_data;
        logic nonres_tbl;
        logic boundary;
        logic sysc_go;
        logic rtn_go;
    } sxd_evt_t;

    typedef struct packed {
        logic last;
        logic hw;
        logic mixed;
    } sxd_dl_t;

    typedef struct packed {
        logic valid;
        logic [31:0] vec;
        logic [31:0] cause;
        logic ctx_frame;
        logic clr_psw;
        logic flush_young;
        logic page_fault;
    } sxd_disp_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_PFPUSH = 2'b01
    } sxd_state_t;
endpackage

/* test/sxd_pipe_model.sv */
// Pipeline side model: signals the end of a page-fault context frame push
module sxd_pipe_model import sxd_pkg::*; (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire sxd_disp_t disp_i,
    input wire logic [7:0] delay_i,
    output logic frame_done_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt_r;
    // Push length follows delay_i, so the bench can make the push prompt or slow
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_r <= 8'h00;
            frame_done_o <= 1'b0;
        end else begin
            frame_done_o <= (cnt_r == 8'h01);
            if (disp_i.valid && disp_i.page_fault) begin
                cnt_r <= delay_i;
            end else if (cnt_r != 8'h00) begin
                cnt_r <= cnt_r - 8'h01;
            end
        end
    end
endmodule

/* test/sxd_dispatch_tb_top.sv */
// Self-checking testbench for the system exception dispatch block
module sxd_dispatch_tb_top import sxd_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock_i = 1'b0;
    logic reset_i = 1'b1;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    sxd_evt_t old_evt = '0;
    sxd_evt_t young_evt = '0;
    sxd_dl_t dl = '0;
    logic frame_done;
    sxd_disp_t disp;
    logic cat_pending;
    logic [7:0] fd_delay = 8'h02;
    sxd_disp_t got;
    int err_total = 0;
    int cmp_count = 0;

    always #5 clock_i = ~clock_i;

    sxd_dispatch u_sxd_dispatch (
        .CLOCK_I(clock_i), .RESET_I(reset_i), .AVS_ADDRESS_I(avs_address),
        .AVS_READ_I(avs_read), .AVS_WRITE_I(avs_write), .AVS_WRITEDATA_I(avs_writedata),
        .AVS_BYTEENABLE_I(4'hF), .AVS_READDATA_O(avs_readdata),
        .AVS_WAITREQUEST_O(avs_waitrequest), .OLD_EVT_I(old_evt), .YOUNG_EVT_I(young_evt),
        .DEADLOCK_I(dl), .FRAME_DONE_I(frame_done), .DISPATCH_O(disp),
        .CAT_PENDING_O(cat_pending)
    );

    sxd_pipe_model u_sxd_pipe_model (
        .clk_i(clock_i), .rst_i(reset_i), .disp_i(disp), .delay_i(fd_delay),
        .frame_done_o(frame_done)
    );

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One Avalon access, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        int n;
        @(posedge clock_i);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= wd;
        n = 0;
        do begin
            @(posedge clock_i);
            n++;
            if (n > 20) begin
                err_total++;
                tally_and_finish();
            end
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    // Present events for one cycle and compare the dispatch that follows
    task automatic ev(input sxd_evt_t o, input sxd_evt_t y, input sxd_dl_t d,
                      input logic v, input logic [31:0] vec, input logic [31:0] cause);
        @(posedge clock_i);
        old_evt <= o;
        young_evt <= y;
        dl <= d;
        @(posedge clock_i);
        old_evt <= '0;
        young_evt <= '0;
        dl <= '0;
        #1;
        got = disp;
        check(32'(got.valid), 32'(v));
        check(got.vec, v ? vec : 32'h0);
        check(got.cause, v ? cause : 32'h0);
        repeat (4) @(posedge clock_i);
    endtask

    function automatic sxd_evt_t mk(input logic [2:0] r);
        mk = '0;
        mk.valid = 1'b1;
        mk.ring = r;
    endfunction

    initial begin
        sxd_evt_t e;
        sxd_evt_t y;
        logic [31:0] d;
        repeat (3) @(posedge clock_i);
        reset_i <= 1'b0;
        #1;
        check(32'(avs_waitrequest), 32'h1);
        check(32'(disp.valid), 32'h0);
        bus(1'b0, REG_CTRL, 32'h0, d);
        check(d, 32'h6);
        e = mk(4);
        e.undef_op = 1'b1;
        ev(e, '0, '0, 1'b1, VEC_SYS, 32'h100);
        check(32'(got.ctx_frame), 32'h0);
        check(32'(got.flush_young), 32'h1);
        bus(1'b0, REG_CAUSE, 32'h0, d);
        check(d, 32'h100);
        bus(1'b1, REG_CAUSE, 32'hFFFF_FFFF, d);
        bus(1'b0, REG_CAUSE, 32'h0, d);
        check(d, 32'h100);
        bus(1'b0, REG_VECTOR, 32'h0, d);
        check(d, VEC_SYS);
        bus(1'b0, 4'h2, 32'h0, d);
        check(d, 32'h0);
        for (int i = 0; i < 7; i++) begin
            e = mk(4);
            {e.vreg_rd, e.vreg_wr, e.vlen_acc, e.vstride_acc, e.vmask_acc, e.vflag_acc,
             e.elem_store} = 7'h40 >> i;
            ev(e, '0, '0, 1'b1, VEC_VV, 32'h200);
        end
        bus(1'b1, REG_CTRL, 32'h7, d);
        e = mk(4);
        e.vreg_rd = 1'b1;
        ev(e, '0, '0, 1'b0, 32'h0, 32'h0);
        e = mk(4);
        e.priv_op = 1'b1;
        ev(e, '0, '0, 1'b1, VEC_SYS, 32'h800);
        e.ring = 3'h0;
        ev(e, '0, '0, 1'b0, 32'h0, 32'h0);
        e = mk(4);
        e.inward_addr = 1'b1;
        ev(e, '0, '0, 1'b1, VEC_SYS, 32'h801);
        e = mk(4);
        e.sysc_outward = 1'b1;
        ev(e, '0, '0, 1'b1, VEC_SYS, 32'h802);
        e = mk(4);
        e.ret_inward = 1'b1;
        ev(e, '0, '0, 1'b0, 32'h0, 32'h0);
        e.ret_ext = 1'b1;
        ev(e, '0, '0, 1'b1, VEC_SYS, 32'h803);
        e = mk(4);
        e.bad_gate = 1'b1;
        y = mk(4);
        y.undef_op = 1'b1;
        ev(e, y, '0, 1'b1, VEC_SYS, 32'h804);
        e = mk(4);
        e.bad_frame_len = 1'b1;
        ev(e, '0, '0, 1'b1, VEC_SYS, 32'h805);
        e = mk(4);
        e.trap_bad = 1'b1;
        ev(e, '0, '0, 1'b1, VEC_SYS, 32'h807);
        for (int i = 0; i < 8; i++) begin
            e = mk(4);
            {e.rd_deny, e.wr_deny, e.ex_deny, e.sdr_inv, e.l1_inv, e.l2_inv, e.lt_inv,
             e.io_inv} = 8'h80 >> i;
            ev(e, '0, '0, 1'b1, VEC_SYS, 32'h901 + i);
        end
        e = mk(4);
        e.nonres_data = 1'b1;
        ev(e, '0, '0, 1'b1, VEC_SYS, 32'hA00);
        check(32'(got.page_fault), 32'h1);
        check(32'(got.ctx_frame), 32'h1);
        e.rd_deny = 1'b1;
        ev(e, '0, '0, 1'b1, VEC_SYS, 32'h901);
        e = mk(4);
        e.nonres_tbl = 1'b1;
        ev(e, '0, '0, 1'b1, VEC_SYS, 32'hA01);
        fd_delay <= 8'h1E;
        ev(e, '0, '0, 1'b1, VEC_SYS, 32'hA01);
        ev(e, '0, '0, 1'b1, VEC_MACH, 32'hB00);
        check(32'(got.ctx_frame), 32'h1);
        check(32'(got.page_fault), 32'h0);
        repeat (30) @(posedge clock_i);
        fd_delay <= 8'h02;
        ev('0, '0, sxd_dl_t'(3'b100), 1'b1, VEC_DEADLOCK, 32'h0);
        ev('0, '0, sxd_dl_t'(3'b010), 1'b1, VEC_DEADLOCK, 32'h400);
        ev('0, '0, sxd_dl_t'(3'b011), 1'b1, VEC_DEADLOCK, 32'h401);
        ev('0, '0, sxd_dl_t'(3'b110), 1'b1, VEC_DEADLOCK, 32'h0);
        e = mk(4);
        e.undef_op = 1'b1;
        ev(e, '0, sxd_dl_t'(3'b100), 1'b1, VEC_SYS, 32'h100);
        e = mk(0);
        e.cr_op = 1'b1;
        e.cr_addr = 16'h803F;
        ev(e, '0, '0, 1'b0, 32'h0, 32'h0);
        check(32'(cat_pending), 32'h0);
        e.cr_addr = 16'h8040;
        ev(e, '0, '0, 1'b0, 32'h0, 32'h0);
        check(32'(cat_pending), 32'h1);
        bus(1'b0, REG_STATUS, 32'h0, d);
        check(d & 32'h1, 32'h1);
        e = mk(4);
        e.boundary = 1'b1;
        ev(e, '0, '0, 1'b1, VEC_SYS, 32'h806);
        check(32'(got.clr_psw), 32'h1);
        check(32'(cat_pending), 32'h0);
        e = mk(4);
        e.cr_op = 1'b1;
        e.cr_addr = 16'h0000;
        ev(e, '0, '0, 1'b0, 32'h0, 32'h0);
        check(32'(cat_pending), 32'h1);
        e = mk(4);
        e.sysc_go = 1'b1;
        ev(e, '0, '0, 1'b0, 32'h0, 32'h0);
        e = mk(4);
        e.boundary = 1'b1;
        ev(e, '0, '0, 1'b0, 32'h0, 32'h0);
        e.rtn_go = 1'b1;
        ev(e, '0, '0, 1'b0, 32'h0, 32'h0);
        e.rtn_go = 1'b0;
        ev(e, '0, '0, 1'b1, VEC_SYS, 32'h806);
        tally_and_finish();
    end
endmodule
